/* design/vsf_pkg.sv */
// Purpose: Shared constants and carrier types of the video scale and filter path
// Assumes: One core clock; all streams are synchronous to it
// Notes: Scale factors are unsigned fixed point with ten fractional bits
package vsf_pkg;
  localparam int          FRAC_W          = 10;
  localparam logic [10:0] UNITY           = 11'h400;
  localparam logic [10:0] ZOOM_INC_MIN    = 11'h040;  // Source step at a ratio of 16
  localparam logic [10:0] ZOOM_INTERP_MIN = 11'h100;  // Source step at a ratio of 4

  localparam logic [7:0]  REG_CTRL        = 8'h00;
  localparam logic [7:0]  REG_SHRINK      = 8'h04;
  localparam logic [7:0]  REG_TARGET      = 8'h08;
  localparam logic [7:0]  REG_ZOOM        = 8'h0c;
  localparam logic [7:0]  REG_STATUS      = 8'h10;

  localparam int          CTRL_SHRINK_EN  = 0;
  localparam int          CTRL_FILT_EN    = 1;
  localparam int          CTRL_VMODE_LSB  = 2;
  localparam int          CTRL_HINTERP_EN = 4;
  localparam int          CTRL_TAPS_LSB   = 5;
  localparam int          CTRL_ZOOM_EN    = 8;
  localparam int          CTRL_DEINT_EN   = 9;
  localparam int          FACT_H_LSB      = 0;
  localparam int          FACT_V_LSB      = 16;
  localparam int          ST_CAP_SURF     = 0;
  localparam int          ST_DISP_SURF    = 1;
  localparam int          ST_INTERLACED   = 2;
  localparam int          ST_FILM         = 3;
  localparam int          ST_LINES_LSB    = 16;

  localparam logic [9:0]  CTRL_RST        = 10'h000;
  localparam logic [9:0]  SHRINK_RST      = 10'h3ff;
  localparam logic [15:0] TARGET_RST      = 16'hffff;
  localparam logic [10:0] ZOOM_RST        = 11'h400;

  localparam logic [9:0]  MOTION_LOW      = 10'h010;
  localparam logic [9:0]  MOTION_HIGH     = 10'h040;
  localparam logic [15:0] REPEAT_THR      = 16'h0100;

  localparam logic signed [10:0] CSC_RV   = 11'sh167;
  localparam logic signed [10:0] CSC_GU   = 11'sh058;
  localparam logic signed [10:0] CSC_GV   = 11'sh0b7;
  localparam logic signed [10:0] CSC_BU   = 11'sh1c6;
  localparam logic signed [9:0]  CHROMA_MID = 10'sh080;

  typedef enum logic [1:0] {VM_DUP, VM_INTERP, VM_EDGE} vsf_vmode_t;
  typedef enum logic [2:0] {HT_BYPASS, HT_2, HT_3, HT_5, HT_9} vsf_taps_t;

  typedef struct packed {logic [7:0] y; logic [7:0] c;} vsf_pix_t;
  typedef struct packed {vsf_pix_t cur; logic [7:0] f1; logic [7:0] f2; logic [7:0] f3; logic [7:0] f4;} vsf_fld_t;
  typedef struct packed {logic valid; logic eol; logic eof; vsf_pix_t pix;} vsf_cap_t;
  typedef struct packed {logic valid; logic eol; logic eof; logic field; vsf_fld_t fld;} vsf_disp_t;
  typedef struct packed {logic valid; logic eol; logic eof; logic surf; vsf_pix_t pix;} vsf_memwr_t;
  typedef struct packed {logic [7:0] r; logic [7:0] g; logic [7:0] b;} vsf_rgb_t;
  typedef struct packed {logic valid; logic eol; vsf_rgb_t rgb;} vsf_out_t;
  typedef struct packed {logic eol; logic odd; vsf_pix_t pix;} vsf_tap_t;
endpackage

/* design/vsf_dda.sv */
// Purpose: Fixed-point position accumulator shared by shrink and zoom stepping
// Assumes: inc never exceeds one whole step (1024)
// Notes: carry is combinational from the held position
`timescale 1ns/10ps
module vsf_dda
  import vsf_pkg::*;
#(
  parameter int W = FRAC_W
)
(
  input  logic         core_clk,
  input  logic         rst_b,
  input  logic         clear,
  input  logic         step,
  input  logic [W:0]   inc,
  output logic [W-1:0] frac,
  output logic         carry
);
  typedef struct packed {logic [W-1:0] acc;} vsf_dda_t;

  vsf_dda_t   s;
  vsf_dda_t   n;
  logic [W:0] sum;

  assign sum   = {1'b0, s.acc} + inc;
  assign carry = sum[W];
  assign frac  = s.acc;

  always_comb
  begin
    n = s;
    if (clear)
      n.acc = '0;
    else if (step)
      n.acc = sum[W-1:0];
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      s <= '0;
    else
      s <= n;
  end
endmodule

/* design/vsf_top.sv */
// Purpose: Capture shrink path and display de-interlace, zoom, filter and colour path
// Assumes: Streams and register port are on core_clk; history fields come from memory
// Notes: Display input is taken on valid and ready; capture input is never stalled
`timescale 1ns/10ps
module vsf_top
  import vsf_pkg::*;
#(
  parameter int MAX_W = 1024
)
(
  input  logic        core_clk,
  input  logic        rst_b,
  input  logic [7:0]  reg_addr,
  input  logic [31:0] reg_wdata,
  input  logic        reg_wr,
  input  logic        reg_rd,
  output logic [31:0] reg_rdata,
  input  vsf_cap_t    cap_in,
  output vsf_memwr_t  mem_wr,
  input  vsf_disp_t   disp_in,
  output logic        disp_ready,
  output logic        disp_surf,
  output logic        disp_next_line,
  output vsf_out_t    pix_out
);
  localparam int XW = $clog2(MAX_W);

  typedef struct packed {
    logic [9:0]        ctrl;
    logic [9:0]        sh_h;
    logic [9:0]        sh_v;
    logic [15:0]       dst_w;
    logic [15:0]       dst_h;
    logic [10:0]       zm_h;
    logic [10:0]       zm_v;
    logic [31:0]       rdata;
    logic [7:0]        c_prev;
    logic [15:0]       c_x;
    logic [15:0]       c_ox;
    logic [15:0]       c_oy;
    logic              cap_surf;
    logic              done_surf;
    logic              c_busy;
    vsf_memwr_t        mwr;
    vsf_pix_t          p0;
    vsf_pix_t          p1;
    logic              have;
    logic              ready;
    logic              eol_in;
    logic              sol;
    logic [15:0]       o_x;
    logic [7:0]        vl_left;
    logic              d_surf;
    logic              next_line;
    logic              last_field;
    logic              interlaced;
    logic              film;
    logic [9:0]        rep_hist;
    logic [15:0]       fdiff;
    vsf_tap_t [8:0]    taps;
    logic [7:0]        u;
    logic [7:0]        v;
    vsf_out_t          out;
  } vsf_state_t;

  vsf_state_t s;
  vsf_state_t n;

  logic [7:0]  clb [MAX_W];
  vsf_pix_t    vlb [MAX_W];

  logic        shr_en;
  logic        filt_en;
  logic        zoom_en;
  logic [10:0] zinc_h;
  logic [10:0] zinc_v;
  logic [9:0]  ch_frac;
  logic        ch_carry;
  logic [9:0]  cv_frac;
  logic        cv_carry;
  logic [9:0]  dh_frac;
  logic        dh_carry;
  logic [9:0]  dv_frac;
  logic        dv_carry;
  logic        take;
  logic        emc;
  logic        line_done;
  logic [XW-1:0] cxi;
  logic [XW-1:0] oxi;
  logic [7:0]  clb_rd;
  vsf_pix_t    vlb_rd;
  vsf_pix_t    vlb_rd_r;
  logic [7:0]  yh;
  logic [7:0]  yv;
  logic        keep_h;
  logic        keep_v;
  vsf_pix_t    dpix;
  vsf_pix_t    zp;
  logic [7:0]  fy;

  function automatic logic [7:0] vsf_avg(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] t;
    t = {1'b0, a} + {1'b0, b};
    return t[8:1];
  endfunction

  // Weight w (in 1024ths) goes to b
  function automatic logic [7:0] vsf_blend(input logic [7:0] a, input logic [7:0] b, input logic [9:0] w);
    logic [18:0] t;
    t = 19'(a) * 19'(UNITY - {1'b0, w}) + 19'(b) * 19'({1'b0, w});
    return t[17:10];
  endfunction

  function automatic logic [7:0] vsf_absd(input logic [7:0] a, input logic [7:0] b);
    return (a > b) ? a - b : b - a;
  endfunction

  function automatic logic [10:0] vsf_clamp(input logic [10:0] f);
    if (f < ZOOM_INC_MIN)
      return ZOOM_INC_MIN;
    else if (f > UNITY)
      return UNITY;
    return f;
  endfunction

  function automatic logic [7:0] vsf_sat(input logic signed [20:0] x);
    if (x < 0)
      return 8'h00;
    else if (x > 21'sh0000ff)
      return 8'hff;
    return x[7:0];
  endfunction

  assign shr_en  = s.ctrl[CTRL_SHRINK_EN];
  assign filt_en = s.ctrl[CTRL_FILT_EN];
  assign zoom_en = s.ctrl[CTRL_ZOOM_EN];
  assign zinc_h  = zoom_en ? vsf_clamp(s.zm_h) : UNITY;
  assign zinc_v  = zoom_en ? vsf_clamp(s.zm_v) : UNITY;

  vsf_dda #(.W(FRAC_W)) u_cap_h (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .clear    (cap_in.valid & cap_in.eol),
    .step     (cap_in.valid & shr_en),
    .inc      ({1'b0, s.sh_h} + 11'h001),
    .frac     (ch_frac),
    .carry    (ch_carry)
  );

  vsf_dda #(.W(FRAC_W)) u_cap_v (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .clear    (cap_in.valid & cap_in.eof),
    .step     (cap_in.valid & cap_in.eol & shr_en),
    .inc      ({1'b0, s.sh_v} + 11'h001),
    .frac     (cv_frac),
    .carry    (cv_carry)
  );

  vsf_dda #(.W(FRAC_W)) u_dsp_h (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .clear    (line_done),
    .step     (s.have),
    .inc      (zinc_h),
    .frac     (dh_frac),
    .carry    (dh_carry)
  );

  vsf_dda #(.W(FRAC_W)) u_dsp_v (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .clear    (take & disp_in.eof),
    .step     (line_done),
    .inc      (zinc_v),
    .frac     (dv_frac),
    .carry    (dv_carry)
  );

  // Capture: a sample is kept when the source position crosses a whole step
  assign keep_h = !shr_en || ch_carry;
  assign keep_v = !shr_en || cv_carry;
  assign cxi    = s.c_x[XW-1:0];
  assign clb_rd = clb[cxi];
  // Filter still runs with shrink off; that case only softens the image
  assign yh = filt_en ? vsf_avg(cap_in.pix.y, s.c_prev) : cap_in.pix.y;
  assign yv = filt_en ? vsf_avg(yh, clb_rd) : yh;

  // Display handshake
  assign take      = disp_in.valid && s.ready;
  // Last source pixel of a line is shown once so both line ends align
  assign line_done = s.have && s.eol_in;
  assign emc       = line_done || (s.have && dh_carry);
  assign oxi       = s.o_x[XW-1:0];
  assign vlb_rd    = vlb[oxi];
  assign vlb_rd_r  = vlb[XW'(s.o_x + 16'h0001)];

  // De-interlace over the current field and four history fields
  always_comb
  begin
    logic [9:0] motion;
    motion = {2'b00, vsf_absd(disp_in.fld.cur.y, disp_in.fld.f2)}
           + {2'b00, vsf_absd(disp_in.fld.f1, disp_in.fld.f3)}
           + {2'b00, vsf_absd(disp_in.fld.f2, disp_in.fld.f4)};
    dpix = disp_in.fld.cur;
    if (s.ctrl[CTRL_DEINT_EN] && s.interlaced)
    begin
      if (s.film || motion < MOTION_LOW)
        dpix.y = disp_in.fld.f1;
      else if (motion < MOTION_HIGH)
        dpix.y = vsf_avg(disp_in.fld.cur.y, disp_in.fld.f1);
    end
  end

  // Zoomed pixel: horizontal then vertical, interpolation only up to ratio 4
  always_comb
  begin
    logic       h_int;
    logic       v_int;
    logic [7:0] hy;
    logic [7:0] vi;
    logic [7:0] e;
    e     = 8'h00;
    h_int = s.ctrl[CTRL_HINTERP_EN] && zinc_h >= ZOOM_INTERP_MIN;
    v_int = zinc_v >= ZOOM_INTERP_MIN;
    hy    = h_int ? vsf_blend(s.p1.y, s.p0.y, dh_frac) : s.p1.y;
    vi    = vsf_blend(hy, vlb_rd.y, dv_frac);
    // Pick the flatter of the vertical and the rising diagonal pair
    if (vsf_absd(vlb_rd.y, hy) <= vsf_absd(vlb_rd_r.y, s.p0.y))
      e = vsf_avg(vlb_rd.y, hy);
    else
      e = vsf_avg(vlb_rd_r.y, s.p0.y);
    zp = {hy, s.p1.c};
    unique case (vsf_vmode_t'(s.ctrl[CTRL_VMODE_LSB +: 2]))
      VM_INTERP: zp.y = v_int ? vi : hy;
      VM_EDGE:   zp.y = v_int ? vsf_avg(e, vi) : hy;
      default:   zp.y = hy;
    endcase
  end

  // Horizontal filter on internal pixels, luma only
  always_comb
  begin
    logic [11:0] acc;
    acc = '0;
    fy  = s.taps[4].pix.y;
    unique case (vsf_taps_t'(s.ctrl[CTRL_TAPS_LSB +: 3]))
      HT_2:
      begin
        fy = vsf_avg(s.taps[4].pix.y, s.taps[3].pix.y);
      end
      HT_3:
      begin
        acc = 12'(s.taps[3].pix.y) + 12'(s.taps[5].pix.y) + {3'b000, s.taps[4].pix.y, 1'b0};
        fy  = acc[9:2];
      end
      HT_5:
      begin
        acc = 12'(s.taps[2].pix.y) + 12'(s.taps[6].pix.y)
            + {3'b000, s.taps[3].pix.y, 1'b0} + {3'b000, s.taps[4].pix.y, 1'b0}
            + {3'b000, s.taps[5].pix.y, 1'b0};
        fy  = acc[10:3];
      end
      HT_9:
      begin
        acc = 12'(s.taps[0].pix.y) + 12'(s.taps[1].pix.y) + 12'(s.taps[7].pix.y) + 12'(s.taps[8].pix.y)
            + {3'b000, s.taps[2].pix.y, 1'b0} + {3'b000, s.taps[3].pix.y, 1'b0}
            + {3'b000, s.taps[5].pix.y, 1'b0} + {3'b000, s.taps[6].pix.y, 1'b0}
            + {2'b00, s.taps[4].pix.y, 2'b00};
        fy  = acc[11:4];
      end
      default:
      begin
        fy = s.taps[4].pix.y;
      end
    endcase
  end

  always_comb
  begin
    logic signed [9:0]  du;
    logic signed [9:0]  dv;
    logic signed [20:0] yy;
    n               = s;
    n.rdata         = '0;
    n.next_line     = 1'b0;
    n.mwr.valid     = 1'b0;
    n.mwr.eol       = 1'b0;
    n.mwr.eof       = 1'b0;
    n.mwr.surf      = s.cap_surf;
    n.out.valid     = 1'b0;
    n.out.eol       = 1'b0;
    du              = $signed({2'b00, s.u}) - CHROMA_MID;
    dv              = $signed({2'b00, s.v}) - CHROMA_MID;
    yy              = 21'($signed({1'b0, fy}));

    if (reg_wr)
    begin
      case (reg_addr)
        REG_CTRL:   n.ctrl = reg_wdata[9:0];
        REG_SHRINK:
        begin
          n.sh_h = reg_wdata[FACT_H_LSB +: 10];
          n.sh_v = reg_wdata[FACT_V_LSB +: 10];
        end
        REG_TARGET:
        begin
          n.dst_w = reg_wdata[FACT_H_LSB +: 16];
          n.dst_h = reg_wdata[FACT_V_LSB +: 16];
        end
        REG_ZOOM:
        begin
          n.zm_h = reg_wdata[FACT_H_LSB +: 11];
          n.zm_v = reg_wdata[FACT_V_LSB +: 11];
        end
        default:    ;
      endcase
    end
    if (reg_rd)
    begin
      case (reg_addr)
        REG_CTRL:   n.rdata = {22'h000000, s.ctrl};
        REG_SHRINK: n.rdata = {6'h00, s.sh_v, 6'h00, s.sh_h};
        REG_TARGET: n.rdata = {s.dst_h, s.dst_w};
        REG_ZOOM:   n.rdata = {5'h00, s.zm_v, 5'h00, s.zm_h};
        REG_STATUS:
        begin
          n.rdata[ST_CAP_SURF]              = s.cap_surf;
          n.rdata[ST_DISP_SURF]             = s.d_surf;
          n.rdata[ST_INTERLACED]            = s.interlaced;
          n.rdata[ST_FILM]                  = s.film;
          n.rdata[ST_LINES_LSB +: 16]       = s.c_oy;
        end
        default:    n.rdata = '0;
      endcase
    end

    // Capture into the surface the display is not reading
    if (cap_in.valid)
    begin
      n.c_prev = cap_in.pix.y;
      n.c_busy = !cap_in.eof;
      n.c_x    = cap_in.eol ? 16'h0000 : s.c_x + 16'h0001;
      if (keep_h && keep_v && (!shr_en || (s.c_ox < s.dst_w && s.c_oy < s.dst_h)))
      begin
        n.mwr.valid = 1'b1;
        n.mwr.pix   = {yv, cap_in.pix.c};
        n.c_ox      = s.c_ox + 16'h0001;
      end
      if (cap_in.eol)
      begin
        n.c_ox    = 16'h0000;
        n.mwr.eol = keep_v;
        if (keep_v)
          n.c_oy = s.c_oy + 16'h0001;
      end
      if (cap_in.eof)
      begin
        n.c_oy      = 16'h0000;
        n.mwr.eof   = 1'b1;
        n.done_surf = s.cap_surf;
      end
    end

    // Display input: one source pixel per take, emitted until the position passes it
    n.ready = emc || (s.ready && !take);
    n.have  = take || (s.have && !emc);
    if (take)
    begin
      n.p0     = (s.sol || line_done) ? dpix : s.p1;
      n.p1     = dpix;
      n.eol_in = disp_in.eol;
      n.sol    = 1'b0;
      n.fdiff  = (s.fdiff > 16'hff00) ? s.fdiff
               : s.fdiff + 16'(vsf_absd(disp_in.fld.cur.y, disp_in.fld.f2));
      if (disp_in.eof)
      begin
        n.last_field = disp_in.field;
        n.interlaced = disp_in.field != s.last_field;
        n.rep_hist   = {s.rep_hist[8:0], s.fdiff < REPEAT_THR};
        // Film shows one repeated field in every five
        n.film       = s.rep_hist[9:5] == s.rep_hist[4:0] && $onehot(s.rep_hist[4:0]);
        n.fdiff      = '0;
        // Two surfaces only: a switch onto the frame being filled waits for a capture gap
        if (s.done_surf != s.cap_surf || !(s.c_busy || cap_in.valid))
          n.d_surf   = s.done_surf;
        if (!(s.c_busy || cap_in.valid))
          n.cap_surf = !s.done_surf;
      end
    end

    if (s.have)
    begin
      n.vl_left = vlb_rd.y;
      n.o_x     = s.o_x + 16'h0001;
      n.taps    = {s.taps[7:0], {s.eol_in, s.o_x[0], zp}};
      n.out.valid = 1'b1;
      n.out.eol   = s.taps[4].eol;
      if (s.taps[4].odd)
        n.v = s.taps[4].pix.c;
      else
        n.u = s.taps[4].pix.c;
      n.out.rgb.r = vsf_sat(yy + ((CSC_RV * dv) >>> 8));
      n.out.rgb.g = vsf_sat(yy - ((CSC_GU * du) >>> 8) - ((CSC_GV * dv) >>> 8));
      n.out.rgb.b = vsf_sat(yy + ((CSC_BU * du) >>> 8));
    end
    if (line_done)
    begin
      n.o_x       = 16'h0000;
      n.sol       = 1'b1;
      n.next_line = dv_carry;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (cap_in.valid && s.c_x < 16'(MAX_W))
      clb[cxi] <= yh;
    if (s.have && dv_carry && s.o_x < 16'(MAX_W))
      vlb[oxi] <= zp;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      s          <= '0;
      s.ctrl     <= CTRL_RST;
      s.sh_h     <= SHRINK_RST;
      s.sh_v     <= SHRINK_RST;
      s.dst_w    <= TARGET_RST;
      s.dst_h    <= TARGET_RST;
      s.zm_h     <= ZOOM_RST;
      s.zm_v     <= ZOOM_RST;
      s.ready    <= 1'b1;
      s.sol      <= 1'b1;
      s.d_surf   <= 1'b1;
      s.done_surf <= 1'b1;
    end
    else
    begin
      s <= n;
    end
  end

  assign reg_rdata      = s.rdata;
  assign mem_wr         = s.mwr;
  assign disp_ready     = s.ready;
  assign disp_surf      = s.d_surf;
  assign disp_next_line = s.next_line;
  assign pix_out        = s.out;
endmodule

/* bench/vsf_top_sva.sv */
// Purpose: Port assertions for vsf_top
// Assumes: Bound from the bench; one clock domain
// Notes: Control word is shadowed from bus writes
`timescale 1ns/10ps
module vsf_top_sva
  import vsf_pkg::*;
#(
  parameter int MAX_W = 1024
)
(
  input logic        core_clk,
  input logic        rst_b,
  input logic [7:0]  reg_addr,
  input logic [31:0] reg_wdata,
  input logic        reg_wr,
  input logic        reg_rd,
  input logic [31:0] reg_rdata,
  input vsf_cap_t    cap_in,
  input vsf_memwr_t  mem_wr,
  input vsf_disp_t   disp_in,
  input logic        disp_ready,
  input logic        disp_surf,
  input logic        disp_next_line,
  input vsf_out_t    pix_out
);
  logic [9:0] ctrl_reg;
  logic [9:0] ctrl_next;
  logic       take;
  logic       cap_mid;
  assign ctrl_next = (reg_wr && reg_addr == REG_CTRL) ? reg_wdata[9:0] : ctrl_reg;
  assign take = disp_in.valid && disp_ready;
  always_ff @(posedge core_clk) ctrl_reg <= rst_b ? ctrl_next : CTRL_RST;
  always_ff @(posedge core_clk) cap_mid <= rst_b && (cap_in.valid ? !cap_in.eof : cap_mid);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  AST_RDATA_SLOT: assert property (reg_rdata != 32'h0 |-> $past(reg_rd))
    else $error("read data outside its slot");
  AST_CAP_PASS: assert property (
    cap_in.valid && !ctrl_reg[CTRL_SHRINK_EN] && !ctrl_reg[CTRL_FILT_EN]
    |=> mem_wr.valid && mem_wr.pix == $past(cap_in.pix))
    else $error("capture pixel not written unchanged");
  AST_CAP_CAUSE: assert property (mem_wr.valid |-> $past(cap_in.valid))
    else $error("memory write without capture pixel");
  AST_EOF_CAUSE: assert property (mem_wr.eof |-> $past(cap_in.valid && cap_in.eof))
    else $error("frame end without captured frame end");
  AST_SURF_HOLD: assert property ($changed(mem_wr.surf) |-> $past(!cap_mid && !cap_in.valid))
    else $error("capture surface moved mid frame");
  AST_NO_TEAR: assert property (mem_wr.valid |-> mem_wr.surf != disp_surf)
    else $error("capture writes the displayed surface");
  AST_DSURF_HOLD: assert property ($changed(disp_surf) |-> $past(take && disp_in.eof))
    else $error("display surface moved mid frame");
  AST_EMIT: assert property (take |-> ##2 pix_out.valid)
    else $error("no output pixel two cycles after take");
  AST_NL_PULSE: assert property (disp_next_line |=> !disp_next_line)
    else $error("next line request longer than a cycle");
  AST_NOZOOM_RDY: assert property (take && !ctrl_reg[CTRL_ZOOM_EN] |=> !disp_ready ##1 disp_ready)
    else $error("display stalled with zoom off");
endmodule

/* bench/vsf_mem_model.sv */
// Purpose: Off-screen memory model feeding the display read stream
// Assumes: One line of flat pixels per go pulse
// Notes: Released data lines show the inverse of the last value
`timescale 1ns/10ps
module vsf_mem_model
  import vsf_pkg::*;
(
  input  logic       core_clk,
  input  logic       go,
  input  logic [7:0] npix,
  input  logic [7:0] yval,
  input  logic       frame_end,
  input  logic       disp_ready,
  output vsf_disp_t  disp_in,
  output logic       busy
);
  logic [7:0] left = 8'h0;
  initial
  begin
    disp_in = '0;
    busy = 1'b0;
  end
  always @(posedge core_clk)
  begin
    if (go)
    begin
      left <= npix;
      busy <= 1'b1;
      disp_in <= '{1'b1, npix == 8'd1, frame_end && npix == 8'd1, 1'b0, '{'{yval, 8'h80}, yval, yval, yval, yval}};
    end
    else if (disp_in.valid && disp_ready && left == 8'd1)
    begin
      busy <= 1'b0;
      disp_in <= '{1'b0, 1'b0, 1'b0, 1'b0, ~disp_in.fld};
    end
    else if (disp_in.valid && disp_ready)
    begin
      left <= left - 8'd1;
      disp_in.eol <= left == 8'd2;
      disp_in.eof <= frame_end && left == 8'd2;
    end
  end
endmodule

/* bench/tb.sv */
// Purpose: Self-checking bench for vsf_top
// Assumes: Memory model drives the display input
// Notes: MAX_W shrunk to keep runs short
`timescale 1ns/10ps
bind vsf_top vsf_top_sva #(.MAX_W(MAX_W)) i_vsf_top_sva (.core_clk(core_clk), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .cap_in(cap_in), .mem_wr(mem_wr), .disp_in(disp_in), .disp_ready(disp_ready), .disp_surf(disp_surf),
  .disp_next_line(disp_next_line), .pix_out(pix_out));
module tb
  import vsf_pkg::*;
();
  logic        core_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  vsf_cap_t    cap_in = '0;
  vsf_memwr_t  mem_wr;
  vsf_disp_t   disp_in;
  logic        disp_ready;
  logic        disp_surf;
  logic        disp_next_line;
  vsf_out_t    pix_out;
  logic        go = 1'b0;
  logic        frame_end = 1'b0;
  logic [7:0]  npix = 8'h0;
  logic        busy;
  logic        last_surf;
  vsf_rgb_t    last_rgb;
  int          err_count = 0;
  int          check_count = 0;
  int          wr_cnt = 0;
  int          pix_cnt = 0;
  int          nl_cnt = 0;
  vsf_top #(.MAX_W(16)) i_vsf_top (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cap_in(cap_in),
    .mem_wr(mem_wr), .disp_in(disp_in), .disp_ready(disp_ready), .disp_surf(disp_surf),
    .disp_next_line(disp_next_line), .pix_out(pix_out));
  vsf_mem_model i_vsf_mem_model (.core_clk(core_clk), .go(go), .npix(npix), .yval(8'h50),
    .frame_end(frame_end), .disp_ready(disp_ready), .disp_in(disp_in), .busy(busy));
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    wr_cnt <= wr_cnt + int'(mem_wr.valid);
    pix_cnt <= pix_cnt + int'(pix_out.valid);
    nl_cnt <= nl_cnt + int'(disp_next_line);
    if (mem_wr.valid)
      last_surf <= mem_wr.surf;
    if (pix_out.valid)
      last_rgb <= pix_out.rgb;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    check_count++;
    if (got !== want)
    begin
      err_count++;
      $display("mismatch %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdck(input logic [7:0] a, input logic [31:0] want);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, want);
  endtask
  task automatic cap_frame(input int lines, input int w);
    for (int l = 0; l < lines; l++)
      for (int p = 0; p < w; p++)
      begin
        @(posedge core_clk);
        cap_in <= '{1'b1, p == w - 1, p == w - 1 && l == lines - 1, '{8'h35 + 8'(p), 8'h80}};
      end
    @(posedge core_clk);
    cap_in <= '0;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic disp_line(input logic [7:0] n, input logic fe);
    @(posedge core_clk);
    npix <= n;
    frame_end <= fe;
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    for (int i = 0; i < 2000 && (i < 2 || busy); i++) @(posedge core_clk);
    repeat (6) @(posedge core_clk);
  endtask
  task automatic t_surface();
    cap_frame(2, 2);
    chk({31'h0, last_surf}, 32'h0);
    disp_line(8'd4, 1'b1);
    chk({31'h0, disp_surf}, 32'h0);
    rdck(REG_STATUS, 32'h00000001);
    cap_frame(2, 2);
    chk({31'h0, last_surf}, 32'h1);
  endtask
  task automatic t_regs();
    rdck(REG_CTRL, {22'h0, CTRL_RST});
    rdck(REG_SHRINK, {6'h0, SHRINK_RST, 6'h0, SHRINK_RST});
    rdck(REG_TARGET, {TARGET_RST, TARGET_RST});
    rdck(REG_ZOOM, {5'h0, ZOOM_RST, 5'h0, ZOOM_RST});
    wr(8'h20, 32'hffffffff);
    rdck(8'h20, 32'h0);
    wr(REG_ZOOM, 32'hffffffff);
    rdck(REG_ZOOM, 32'h07ff07ff);
  endtask
  task automatic t_capture();
    logic [31:0] cfg [4] = '{32'h0, 32'h1, 32'h3, 32'h2};
    logic [31:0] shr [4] = '{32'h03ff03ff, 32'h01ff01ff, 32'h02ff02ff, 32'h03ff03ff};
    int          want [4] = '{32, 8, 18, 32};
    int          base;
    wr(REG_TARGET, 32'hffffffff);
    for (int k = 0; k < 4; k++)
    begin
      wr(REG_SHRINK, shr[k]);
      wr(REG_CTRL, cfg[k]);
      base = wr_cnt;
      cap_frame(4, 8);
      chk(32'(wr_cnt - base), 32'(want[k]));
    end
  endtask
  task automatic t_display();
    logic [31:0] cfg [8] = '{32'h0, 32'h4, 32'h8, 32'h10, 32'h20, 32'h40, 32'h60, 32'h80};
    logic [31:0] zf [3] = '{32'h04000200, 32'h04000040, 32'h04000020};
    int          lo [3] = '{14, 110, 110};
    int          nlb;
    int          base;
    for (int k = 0; k < 8; k++)
    begin
      wr(REG_CTRL, cfg[k]);
      disp_line(8'd8, 1'b0);
      base = pix_cnt;
      disp_line(8'd8, 1'b1);
      chk(32'(pix_cnt - base), 32'd8);
      chk({8'h0, last_rgb}, 32'h00505050);
    end
    wr(REG_CTRL, 32'h100);
    for (int k = 0; k < 3; k++)
    begin
      wr(REG_ZOOM, zf[k]);
      base = pix_cnt;
      nlb = nl_cnt;
      disp_line(8'd8, 1'b1);
      chk({31'h0, pix_cnt - base >= lo[k] && pix_cnt - base <= lo[k] + 10}, 32'h1);
      chk({8'h0, last_rgb}, 32'h00505050);
      chk(32'(nl_cnt - nlb), 32'd1);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    t_surface();
    t_regs();
    t_capture();
    t_display();
    results();
  end
  initial
  begin
    #(50 * 20000);
    err_count++;
    results();
  end
endmodule
